// ### rtl/cmd_timing_pkg.sv
// Constants, types and timing parameters for the command timing unit.
// Assumes a single clock domain, one cycle per processor clock.
// Overview of operation
// - Pointer port write picks a parameter; next data port write loads it while speed_unlocked is high.
// - Index comes from data bits 7,6,3,2; indices two and eleven unused.
// - Pointer and data ports are write-only; reads get no answer.
// - Latch strobe rises 0 to 3 clocks after address strobe; default 0.
// - Latch strobe lasts 1 to 3 clocks; default 1.
// - Command delay counts clocks from end of status state to command.
// - Narrow memory and all bus I/O use narrow command delay; default 1.
// - Narrow cycles insert narrow wait states; default 4.
// - Wide I/O cycles use wide I/O wait states; default 1.
// - Wide memory cycles: delay default 0, waits default 1.
// - Zero-wait signal ends a cycle only after minimum waits; default 0.
// - Local cycles: separate read and write wait counts, both default 1.
// - Local memory cycles always use zero command delay.
// - Local I/O cycles use local I/O command delay; default 1.
// - Local I/O uses local waits, stretched while channel ready is low.
// - Each wait state adds two processor clocks.
// - High-speed mode may add one extra wait state for sync.
// - Coprocessor error while coprocessor busy is active latches busy output to CPU low.
// - A write to clear-busy port clears latch unless a coprocessor error is present that clock; data ignored.
// - Any write to coprocessor reset port pulses coprocessor reset.
// - Once cleared, busy output follows coprocessor busy input again.
// - Coprocessor reset also asserts while system reset is active.
package cmd_timing_pkg;
  localparam logic [7:0] ptr_port_addr    = 8'h72;
  localparam logic [7:0] data_port_addr   = 8'h73;
  localparam logic [7:0] busy_clr_addr    = 8'hf0;
  localparam logic [7:0] cop_rst_addr     = 8'hf1;
  localparam int         ptr_bit_3        = 7;
  localparam int         ptr_bit_2        = 6;
  localparam int         ptr_bit_1        = 3;
  localparam int         ptr_bit_0        = 2;
  localparam logic [3:0] idx_strobe_delay = 4'h0;
  localparam logic [3:0] idx_strobe_width = 4'h1;
  localparam logic [3:0] idx_narrow_delay = 4'h3;
  localparam logic [3:0] idx_narrow_wait  = 4'h4;
  localparam logic [3:0] idx_wide_io_wait = 4'h5;
  localparam logic [3:0] idx_wide_mem_dly = 4'h6;
  localparam logic [3:0] idx_wide_mem_ws  = 4'h7;
  localparam logic [3:0] idx_zero_min     = 4'h8;
  localparam logic [3:0] idx_local_rd_ws  = 4'h9;
  localparam logic [3:0] idx_local_wr_ws  = 4'ha;
  localparam logic [3:0] idx_local_io_dly = 4'hc;
  localparam logic [1:0] rst_strobe_delay = 2'h0;
  localparam logic [1:0] rst_strobe_width = 2'h1;
  localparam logic [1:0] min_strobe_width = 2'h1;
  localparam logic [3:0] rst_narrow_delay = 4'h1;
  localparam logic [3:0] rst_narrow_wait  = 4'h4;
  localparam logic [3:0] rst_wide_io_wait = 4'h1;
  localparam logic [3:0] rst_wide_mem_dly = 4'h0;
  localparam logic [3:0] rst_wide_mem_ws  = 4'h1;
  localparam logic [3:0] rst_zero_min     = 4'h0;
  localparam logic [3:0] rst_local_rd_ws  = 4'h1;
  localparam logic [3:0] rst_local_wr_ws  = 4'h1;
  localparam logic [3:0] rst_local_io_dly = 4'h1;
  localparam logic [5:0] clks_per_wait    = 6'h02;
  localparam int         cop_rst_ns       = 100;
  localparam int         clk_period_ns    = 4;
  localparam logic [7:0] cop_rst_cycles   =
    8'((cop_rst_ns + clk_period_ns - 1) / clk_period_ns);

  typedef struct packed {
    logic       strobe;
    logic       is_write;
    logic [7:0] addr;
    logic [7:0] data;
  } io_write_t;

  typedef struct packed {
    logic       is_mem;
    logic       is_write;
    logic       local_sel;
    logic       wide_mem;
    logic       wide_io;
  } cycle_class_t;

  typedef struct packed {
    logic [1:0] strobe_delay;
    logic [1:0] strobe_width;
    logic [3:0] narrow_delay;
    logic [3:0] narrow_wait;
    logic [3:0] wide_io_wait;
    logic [3:0] wide_mem_dly;
    logic [3:0] wide_mem_ws;
    logic [3:0] zero_min;
    logic [3:0] local_rd_ws;
    logic [3:0] local_wr_ws;
    logic [3:0] local_io_dly;
  } timing_regs_t;

  typedef enum logic [2:0] {
    st_idle   = 3'b000,
    st_status = 3'b001,
    st_delay  = 3'b010,
    st_cmd    = 3'b011,
    st_hold   = 3'b100
  } cyc_state_t;
endpackage

// ### rtl/cmd_timing.sv
// Programmable command timing unit with coprocessor busy and reset logic.
// Assumes all inputs synchronous to clk, which is the processor clock.
`timescale 1ns/1ps
module cmd_timing (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        nrst,
  input  wire logic                        sys_reset,
  // I/O write port from the CPU
  input  wire cmd_timing_pkg::io_write_t   io_wr,
  // Cycle start and class
  input  wire logic                        addr_strobe,
  input  wire cmd_timing_pkg::cycle_class_t cyc,
  input  wire logic                        high_speed,
  input  wire logic                        sync_extra,
  input  wire logic                        zero_wait_n,
  input  wire logic                        chan_ready,
  input  wire logic                        speed_unlocked,
  // Bus strobes
  output logic                             bus_latch_strobe,
  output logic                             bus_memory_read_cmd,
  output logic                             bus_memory_write_cmd,
  output logic                             bus_io_read_cmd,
  output logic                             bus_io_write_cmd,
  output logic                             cpu_ready,
  // Coprocessor
  input  wire logic                        cop_busy_n,
  input  wire logic                        cop_error_n,
  output logic                             cpu_busy_output,
  output logic                             cop_reset
);
  import cmd_timing_pkg::*;

  timing_regs_t regs_q;
  logic [3:0]   ptr_q;
  logic         ptr_valid_q;
  logic         busy_latch_q;
  logic [7:0]   cop_rst_cnt_q;
  cyc_state_t   state_q;
  logic [3:0]   delay_cnt_q;
  logic [5:0]   wait_cnt_q;
  logic [5:0]   wait_total_q;
  logic [5:0]   zero_total_q;
  logic [1:0]   lstr_cnt_q;
  logic [1:0]   lstr_w_q;
  logic         lstr_on_q;
  cycle_class_t cls_q;

  // Write decode
  wire wr_ptr  = io_wr.strobe && io_wr.is_write && io_wr.addr == ptr_port_addr;
  wire wr_data = io_wr.strobe && io_wr.is_write
                 && io_wr.addr == data_port_addr;
  wire wr_clr  = io_wr.strobe && io_wr.is_write && io_wr.addr == busy_clr_addr;
  wire wr_crst = io_wr.strobe && io_wr.is_write && io_wr.addr == cop_rst_addr;
  wire [3:0] wr_idx = {io_wr.data[ptr_bit_3], io_wr.data[ptr_bit_2],
                       io_wr.data[ptr_bit_1], io_wr.data[ptr_bit_0]};
  wire load = wr_data && ptr_valid_q && speed_unlocked;

  // Parameter registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ptr_q       <= 4'h0;
      ptr_valid_q <= 1'b0;
    end else if (wr_ptr) begin
      ptr_q       <= wr_idx;
      ptr_valid_q <= 1'b1;
    end else if (wr_data) begin
      ptr_valid_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      regs_q <= '{rst_strobe_delay, rst_strobe_width, rst_narrow_delay,
                  rst_narrow_wait, rst_wide_io_wait, rst_wide_mem_dly,
                  rst_wide_mem_ws, rst_zero_min, rst_local_rd_ws,
                  rst_local_wr_ws, rst_local_io_dly};
    end else if (load) begin
      unique case (ptr_q)
        idx_strobe_delay: regs_q.strobe_delay <= io_wr.data[1:0];
        idx_strobe_width: regs_q.strobe_width <= io_wr.data[1:0];
        idx_narrow_delay: regs_q.narrow_delay <= io_wr.data[3:0];
        idx_narrow_wait:  regs_q.narrow_wait  <= io_wr.data[3:0];
        idx_wide_io_wait: regs_q.wide_io_wait <= io_wr.data[3:0];
        idx_wide_mem_dly: regs_q.wide_mem_dly <= io_wr.data[3:0];
        idx_wide_mem_ws:  regs_q.wide_mem_ws  <= io_wr.data[3:0];
        idx_zero_min:     regs_q.zero_min     <= io_wr.data[3:0];
        idx_local_rd_ws:  regs_q.local_rd_ws  <= io_wr.data[3:0];
        idx_local_wr_ws:  regs_q.local_wr_ws  <= io_wr.data[3:0];
        idx_local_io_dly: regs_q.local_io_dly <= io_wr.data[3:0];
        default: ;
      endcase
    end
  end

  // Cycle classification
  wire [3:0] sel_delay = cyc.local_sel ? (cyc.is_mem ? 4'h0
                                          : regs_q.local_io_dly)
                       : (cyc.is_mem && cyc.wide_mem) ? regs_q.wide_mem_dly
                       : regs_q.narrow_delay;
  wire [3:0] sel_ws = cyc.local_sel ? (cyc.is_write ? regs_q.local_wr_ws
                                       : regs_q.local_rd_ws)
                    : (cyc.is_mem && cyc.wide_mem) ? regs_q.wide_mem_ws
                    : (!cyc.is_mem && cyc.wide_io) ? regs_q.wide_io_wait
                    : regs_q.narrow_wait;
  wire [4:0] ws_eff = {1'b0, sel_ws} + 5'(high_speed && sync_extra);
  wire [5:0] ws_clks = 6'({1'b0, ws_eff} * clks_per_wait);
  wire [5:0] zm_clks = 6'({2'h0, regs_q.zero_min} * clks_per_wait);
  wire [1:0] lw_eff = (regs_q.strobe_width < min_strobe_width)
                      ? min_strobe_width : regs_q.strobe_width;

  wire zero_end = !zero_wait_n && wait_cnt_q >= zero_total_q;
  wire wait_end = (wait_cnt_q >= wait_total_q || zero_end)
                  && (chan_ready || !cls_q.local_sel || cls_q.is_mem);

  // Cycle sequencer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q      <= st_idle;
      cls_q        <= '0;
      delay_cnt_q  <= 4'h0;
      wait_cnt_q   <= 6'h00;
      wait_total_q <= 6'h00;
      zero_total_q <= 6'h00;
    end else begin
      unique case (state_q)
        st_idle: if (addr_strobe) begin
          state_q      <= st_status;
          cls_q        <= cyc;
          delay_cnt_q  <= sel_delay;
          wait_total_q <= ws_clks;
          zero_total_q <= zm_clks;
          wait_cnt_q   <= 6'h00;
        end
        st_status: state_q <= (delay_cnt_q == 4'h0) ? st_cmd : st_delay;
        st_delay: begin
          delay_cnt_q <= delay_cnt_q - 4'h1;
          if (delay_cnt_q == 4'h1) state_q <= st_cmd;
        end
        st_cmd: begin
          if (wait_end) state_q <= st_hold;
          else if (wait_cnt_q != '1) begin
            wait_cnt_q <= wait_cnt_q + 6'h01;
          end
        end
        st_hold: state_q <= st_idle;
        default: state_q <= st_idle;
      endcase
    end
  end

  // Latch strobe timing
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lstr_cnt_q <= 2'h0;
      lstr_w_q   <= 2'h0;
      lstr_on_q  <= 1'b0;
    end else if (state_q == st_idle && addr_strobe) begin
      lstr_cnt_q <= regs_q.strobe_delay;
      lstr_w_q   <= lw_eff;
      lstr_on_q  <= 1'b1;
    end else if (lstr_on_q && lstr_cnt_q != 2'h0) begin
      lstr_cnt_q <= lstr_cnt_q - 2'h1;
    end else if (lstr_on_q) begin
      lstr_w_q  <= lstr_w_q - 2'h1;
      lstr_on_q <= (lstr_w_q != 2'h1);
    end
  end

  wire in_cmd = state_q == st_cmd;
  assign bus_latch_strobe     = lstr_on_q && lstr_cnt_q == 2'h0;
  assign bus_memory_read_cmd  = in_cmd && cls_q.is_mem && !cls_q.is_write;
  assign bus_memory_write_cmd = in_cmd && cls_q.is_mem && cls_q.is_write;
  assign bus_io_read_cmd      = in_cmd && !cls_q.is_mem && !cls_q.is_write;
  assign bus_io_write_cmd     = in_cmd && !cls_q.is_mem && cls_q.is_write;
  assign cpu_ready            = state_q == st_hold;

  // Coprocessor busy latch and reset
  wire cop_err = !cop_error_n && !cop_busy_n;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy_latch_q <= 1'b0;
    end else if (cop_err) begin
      busy_latch_q <= 1'b1;
    end else if (wr_clr || cop_reset) begin
      busy_latch_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cop_rst_cnt_q <= 8'h00;
    end else if (wr_crst) begin
      cop_rst_cnt_q <= cop_rst_cycles;
    end else if (cop_rst_cnt_q != 8'h00) begin
      cop_rst_cnt_q <= cop_rst_cnt_q - 8'h01;
    end
  end

  assign cop_reset       = sys_reset || cop_rst_cnt_q != 8'h00;
  assign cpu_busy_output = cop_busy_n && !busy_latch_q;
endmodule // cmd_timing

// ### sim/cmd_timing_properties.sv
// Port checker for the command timing unit.
// Assumes it is bound to cmd_timing and sees only its ports.
`timescale 1ns/1ps
module cmd_timing_properties (
  // Clock and reset
  input wire logic                      clk,
  input wire logic                      nrst,
  input wire logic                      sys_reset,
  // Inputs watched
  input wire cmd_timing_pkg::io_write_t io_wr,
  input wire logic                      addr_strobe,
  input wire logic                      cop_busy_n,
  input wire logic                      cop_error_n,
  // Outputs watched
  input wire logic                      bus_latch_strobe,
  input wire logic                      bus_memory_read_cmd,
  input wire logic                      bus_memory_write_cmd,
  input wire logic                      bus_io_read_cmd,
  input wire logic                      bus_io_write_cmd,
  input wire logic                      cpu_ready,
  input wire logic                      cpu_busy_output,
  input wire logic                      cop_reset
);
  import cmd_timing_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire [3:0] cmds   = {bus_memory_read_cmd, bus_memory_write_cmd,
                       bus_io_read_cmd, bus_io_write_cmd};
  wire       io_hit = io_wr.strobe & io_wr.is_write;
  wire       clr_wr = io_hit & (io_wr.addr == busy_clr_addr);
  wire       rst_wr = io_hit & (io_wr.addr == cop_rst_addr);
  sequence s_err;
    !cop_error_n && !cop_busy_n ##1 cop_error_n && !clr_wr && !cop_reset;
  endsequence
  sequence s_pulse;
    cop_reset [*8] ##1 cop_reset [*8] ##1 cop_reset [*8] ##1 cop_reset;
  endsequence
  a_cmd_exclusive: assert property ($onehot0(cmds))
    else $error("two commands at once");
  a_busy_latch: assert property (s_err |-> !cpu_busy_output)
    else $error("busy output not latched low");
  a_busy_clear: assert property (clr_wr && cop_error_n |=>
    cpu_busy_output == cop_busy_n) else $error("busy latch not cleared");
  a_cop_pulse: assert property (rst_wr && !sys_reset |=>
    s_pulse ##1 !cop_reset) else $error("coprocessor reset length");
  a_sysrst_cop: assert property (sys_reset |-> cop_reset)
    else $error("system reset does not reach coprocessor");
  a_ready_single: assert property (cpu_ready |=>
    !cpu_ready && cmds == 0) else $error("ready not a single pulse");
  a_strobe_lead: assert property (addr_strobe |->
    ##[0:4] bus_latch_strobe) else $error("latch strobe late");
  a_strobe_width: assert property ($rose(bus_latch_strobe) |->
    ##[1:3] !bus_latch_strobe) else $error("latch strobe too wide");
endmodule // cmd_timing_properties

bind cmd_timing cmd_timing_properties cmd_timing_properties_i (
  .clk(clk), .nrst(nrst), .sys_reset(sys_reset), .io_wr(io_wr),
  .addr_strobe(addr_strobe), .cop_busy_n(cop_busy_n),
  .cop_error_n(cop_error_n), .bus_latch_strobe(bus_latch_strobe),
  .bus_memory_read_cmd(bus_memory_read_cmd),
  .bus_memory_write_cmd(bus_memory_write_cmd),
  .bus_io_read_cmd(bus_io_read_cmd), .bus_io_write_cmd(bus_io_write_cmd),
  .cpu_ready(cpu_ready), .cpu_busy_output(cpu_busy_output),
  .cop_reset(cop_reset));

// ### sim/cop_model.sv
// Numeric coprocessor model: busy and error set by the bench.
// Assumes cop_reset is active high and clears both flags.
`timescale 1ns/1ps
module cop_model (
  // Control
  input wire logic clk,
  input wire logic cop_reset,
  input wire logic want_busy,
  input wire logic want_err,
  // Status
  output logic     cop_busy_n,
  output logic     cop_error_n
);
  always_ff @(posedge clk) begin
    cop_busy_n  <= cop_reset | ~want_busy;
    cop_error_n <= cop_reset | ~want_err;
  end
endmodule // cop_model

// ### sim/cmd_timing_tb.sv
// Self-checking bench for the command timing unit.
// Assumes a 250 MHz clock; inputs change on the falling edge.
`timescale 1ns/1ps
module cmd_timing_tb;
  import cmd_timing_pkg::*;
  logic         clk = 0, nrst = 0, sys_reset = 0, addr_strobe = 0;
  logic         high_speed = 0, sync_extra = 0, zero_wait_n = 1;
  logic         chan_ready = 1, speed_unlocked = 1;
  logic         want_busy = 0, want_err = 0;
  io_write_t    io_wr = '0;
  cycle_class_t cyc = '0;
  logic         latch_s, mrd, mwr, ird, iwr, rdy, busy_o, cop_rst;
  logic         busy_n, err_n;
  int           fails = 0, checked = 0, cycles = 0, rdy_n = 0;
  int           base, lead, len, n;
  always #2 clk = ~clk;
  always @(negedge clk) if (rdy === 1'b1) rdy_n++;
  cmd_timing cmd_timing_i (.clk(clk), .nrst(nrst), .sys_reset(sys_reset),
    .io_wr(io_wr), .addr_strobe(addr_strobe), .cyc(cyc),
    .high_speed(high_speed), .sync_extra(sync_extra),
    .zero_wait_n(zero_wait_n), .chan_ready(chan_ready),
    .speed_unlocked(speed_unlocked), .bus_latch_strobe(latch_s),
    .bus_memory_read_cmd(mrd), .bus_memory_write_cmd(mwr),
    .bus_io_read_cmd(ird), .bus_io_write_cmd(iwr), .cpu_ready(rdy),
    .cop_busy_n(busy_n), .cop_error_n(err_n), .cpu_busy_output(busy_o),
    .cop_reset(cop_rst));
  cop_model cop_model_i (.clk(clk), .cop_reset(cop_rst),
    .want_busy(want_busy), .want_err(want_err), .cop_busy_n(busy_n),
    .cop_error_n(err_n));
  task automatic print_verdict;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      print_verdict();
    end
  end
  task automatic check(string w, logic [15:0] e, logic [15:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %0d seen %0d", w, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge clk) io_wr = '{1'b1, 1'b1, a, d};
    @(negedge clk) io_wr = '0;
  endtask
  task automatic setp(logic [3:0] i, logic [7:0] v);
    wr(ptr_port_addr, {i[3:2], 2'h0, i[1:0], 2'h0});
    wr(data_port_addr, v);
  endtask
  // One bus cycle: lead to command, command kind and length
  task automatic run(cycle_class_t c);
    int k, r0;
    logic [3:0] kind, want;
    r0 = rdy_n;
    want = {c.is_mem & ~c.is_write, c.is_mem & c.is_write,
            ~c.is_mem & ~c.is_write, ~c.is_mem & c.is_write};
    @(negedge clk) addr_strobe = 1;
    cyc = c;
    @(negedge clk) addr_strobe = 0;
    lead = 1;
    len = 0;
    for (k = 0; k < 200 && !(mrd | mwr | ird | iwr); k++) @(negedge clk) lead++;
    kind = {mrd, mwr, ird, iwr};
    for (k = 0; k < 200 && (mrd | mwr | ird | iwr); k++) @(negedge clk) len++;
    repeat (4) @(negedge clk);
    check("command kind", want, kind);
    check("ready pulses", 1, rdy_n - r0);
  endtask
  // Latch strobe delay and width after one address strobe
  task automatic strobe_probe(logic [1:0] d, logic [1:0] w);
    int k, first, wid;
    first = 0;
    wid = 0;
    setp(idx_strobe_delay, {6'h00, d});
    setp(idx_strobe_width, {6'h00, w});
    @(negedge clk) addr_strobe = 1;
    cyc = 5'b10010;
    @(negedge clk) addr_strobe = 0;
    for (k = 1; k < 12; k++) begin
      if (latch_s === 1'b1 && wid == 0) first = k;
      if (latch_s === 1'b1) wid++;
      @(negedge clk);
    end
    check("latch lead", d + 1, first);
    check("latch width", w, wid);
  endtask
  task automatic cop_error;
    want_busy = 1;
    want_err = 1;
    repeat (3) @(negedge clk);
    want_busy = 0;
    want_err = 0;
    repeat (3) @(negedge clk);
    check("busy latched", 0, busy_o);
  endtask
  // Default timing of wide and narrow memory, wide I/O and local memory read cycles after reset
  task automatic default_cycles;
    run(5'b10010);
    base = lead;
    check("wide mem lead", 2, lead);
    check("wide mem len", 3, len);
    run(5'b10000);
    check("narrow lead", base + 1, lead);
    check("narrow len", 9, len);
    run(5'b01001);
    check("wide io len", 3, len);
    check("io lead", base + 1, lead);
    run(5'b10100);
    check("local mem lead", base, lead);
    check("local rd len", 3, len);
  endtask
  // Programmed local write waits and local I/O delay
  task automatic local_cycles;
    setp(idx_local_wr_ws, 8'h02);
    run(5'b11100);
    check("local wr len", 5, len);
    setp(idx_local_io_dly, 8'h07);
    run(5'b00100);
    check("local io lead", base + 7, lead);
  endtask
  // Unused indices and locked writes leave parameters alone
  task automatic guarded_writes;
    setp(idx_narrow_delay, 8'h0f);
    setp(idx_narrow_wait, 8'h00);
    setp(4'h2, 8'h09);
    setp(4'hb, 8'h09);
    speed_unlocked = 0;
    setp(idx_narrow_wait, 8'h03);
    speed_unlocked = 1;
    run(5'b10000);
    check("max delay lead", base + 15, lead);
    check("locked len", 1, len);
  endtask
  // Read of the data port is ignored; sync adds one wait
  task automatic sync_and_read;
    wr(ptr_port_addr, 8'h40);
    @(negedge clk) io_wr = '{1'b1, 1'b0, data_port_addr, 8'h05};
    @(negedge clk) io_wr = '0;
    high_speed = 1;
    sync_extra = 1;
    run(5'b10000);
    high_speed = 0;
    check("sync len", 3, len);
  endtask
  // Zero-wait request ends the cycle after the minimum
  task automatic zero_wait;
    setp(idx_narrow_wait, 8'h04);
    setp(idx_zero_min, 8'h01);
    zero_wait_n = 0;
    run(5'b10000);
    zero_wait_n = 1;
    check("zero wait cut", 3, len);
  endtask
  // Channel ready held low stretches a local I/O cycle
  task automatic chan_stretch;
    chan_ready = 0;
    fork
      run(5'b00100);
      begin
        repeat (20) @(negedge clk);
        chan_ready = 1;
      end
    join
    check("stretch lead", base + 7, lead);
    check("ready stretch", 11, len);
  endtask
  // Busy latch cleared by a port write, then follows busy
  task automatic busy_clear;
    cop_error();
    wr(busy_clr_addr, 8'h5a);
    @(negedge clk);
    check("busy follows", 1, busy_o);
    want_busy = 1;
    repeat (2) @(negedge clk);
    check("busy tracks", 0, busy_o);
    want_busy = 0;
    repeat (2) @(negedge clk);
  endtask
  // Coprocessor reset by port write and by system reset
  task automatic cop_resets;
    cop_error();
    wr(cop_rst_addr, 8'h00);
    n = cop_rst;
    repeat (40) @(negedge clk) n += cop_rst;
    check("cop reset len", cop_rst_cycles, n);
    check("busy after reset", 1, busy_o);
    sys_reset = 1;
    @(negedge clk);
    check("sys cop reset", 1, cop_rst);
  endtask
  initial begin
    repeat (5) @(negedge clk);
    nrst = 1;
    default_cycles();
    strobe_probe(2'h2, 2'h3);
    strobe_probe(2'h3, 2'h1);
    local_cycles();
    guarded_writes();
    sync_and_read();
    zero_wait();
    chan_stretch();
    busy_clear();
    cop_resets();
    print_verdict();
  end
endmodule // cmd_timing_tb
